// ==== hdl/rfis_irq_status.v ====
// Interrupt status register and interrupt request line of the reader.
`timescale 1ns/1ps
`default_nettype none
`include "rfis_consts.vh"
// What this block does
// R1: Status clears on reset, enable low, protocol write.
// R2: End of status read clears bits and line.
// R3: Host acknowledges by reading the status or by writing protocol control.
// R4: During transmit only FIFO and transmit flags change.
// R5: During receive only receive flag, no interrupt.
// R6: Interrupt raised only at end of phase or on an unmasked no-response timeout.
// R7: Transmit flag at start, interrupt at end.
// R8: Receive flag at frame start, interrupt at end.
// R9: FIFO flag below 4 in transmit only, never set in receive.
// R10: CRC flag only when receive CRC enabled.
// R11: Parity and framing faults in bits three, two.
// R12: Collision flag on single subcarrier collision.
// R13: No-response flag after programmed wait expires.
// R14: Mask register gates the no-response interrupt, and a receive-end interrupt only when it meets a clearing condition.
// R15: Flags accumulate until a clearing condition of R1 or R2.
module rfis_irq_status #(
    parameter FIFO_W = 7,
    parameter NORESP_W = 8
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_enable,
    input wire [`RFIS_ADDR_W-1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_rd_end,
    input wire i_tx_start,
    input wire i_tx_done,
    input wire i_rx_sof,
    input wire i_rx_done,
    input wire [FIFO_W-1:0] i_fifo_bits,
    input wire i_crc_err,
    input wire i_parity_err,
    input wire i_framing_err,
    input wire i_collision,
    input wire i_noresp_tick,
    output reg [7:0] o_rdata,
    output reg o_irq,
    output reg o_rx_decoder_en,
    output reg o_tx_active,
    output reg o_rx_active
);
    // ****************************************
    // Control registers and phase tracking
    // ****************************************
    reg no_rx_crc_reg;
    reg [5:0] mask_reg;
    reg [NORESP_W-1:0] noresp_time_reg;
    reg [NORESP_W-1:0] noresp_cnt_reg;
    reg noresp_run_reg;
    reg tx_reg;
    reg rx_reg;
    reg irq_next;
    wire [7:0] flags;
    wire [7:0] set_vec;
    wire clr;
    wire rd_status;
    wire tx_end;
    wire rx_end;
    wire noresp_hit;
    wire fifo_high;
    wire fifo_low;
    wire [5:0] masked;
    wire [NORESP_W+7:0] noresp_time_ext;

    assign noresp_time_ext = {8'h00, noresp_time_reg};
    assign rd_status = i_rd && (i_addr == `RFIS_ADDR_STATUS);
    // R1: clearing conditions
    // R2: read end clears
    // R3: status read end or protocol write acknowledges
    assign clr = !i_rst_n || !i_enable || (i_wr && i_addr == `RFIS_ADDR_PROTO_CTRL)
                 || (i_rd_end && i_addr == `RFIS_ADDR_STATUS);
    assign tx_end = tx_reg && i_tx_done;
    assign rx_end = rx_reg && i_rx_done;
    assign noresp_hit = noresp_run_reg && (noresp_cnt_reg == noresp_time_reg);
    // R9: FIFO level thresholds
    assign fifo_high = rx_reg && (i_fifo_bits > `RFIS_FIFO_HIGH);
    assign fifo_low = tx_reg && (i_fifo_bits < `RFIS_FIFO_LOW);

    // ****************************************
    // Flag set terms
    // ****************************************
    // R7: transmit flag at start
    assign set_vec[`RFIS_BIT_TX] = i_enable && i_tx_start;
    // R8: receive flag at SOF
    // R4: receive blocked during transmit
    assign set_vec[`RFIS_BIT_RX] = i_enable && i_rx_sof && !tx_reg;
    // R4: FIFO may change in transmit
    // R5: only receive flag during receive
    assign set_vec[`RFIS_BIT_FIFO] = i_enable && (fifo_low || (fifo_high && 1'b0));
    // R10: CRC flag gated by option
    // R11: parity and framing faults
    // R12: collision flag
    assign set_vec[`RFIS_BIT_CRC] = i_enable && !tx_reg && !rx_reg && i_crc_err
                                    && !no_rx_crc_reg;
    assign set_vec[`RFIS_BIT_PARITY] = i_enable && !tx_reg && !rx_reg && i_parity_err;
    assign set_vec[`RFIS_BIT_FRAMING] = i_enable && !tx_reg && !rx_reg && i_framing_err;
    assign set_vec[`RFIS_BIT_COLL] = i_enable && !tx_reg && !rx_reg && i_collision;
    // R13: no-response timeout
    assign set_vec[`RFIS_BIT_NORESP] = i_enable && !tx_reg && !rx_reg && noresp_hit;

    // R15: sticky flags
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_flag
            rfis_flag_bit u_flag (
                .i_clk(i_clk),
                .i_clr(clr),
                .i_set(set_vec[g] && i_rst_n),
                .o_flag(flags[g])
            );
        end
    endgenerate

    // R14: mask gating
    assign masked = flags[5:0] & mask_reg;

    // ****************************************
    // Interrupt request
    // ****************************************
    always @* begin
        irq_next = o_irq;
        // R6: raise only at phase end or unmasked no-response hit
        if (tx_end || rx_end || (noresp_hit && mask_reg[`RFIS_BIT_NORESP])) begin
            irq_next = 1'b1;
        end
        if (clr) begin
            irq_next = 1'b0;
        end
        if (rx_end && (|masked[5:1] || flags[`RFIS_BIT_RX]) && i_enable && i_rst_n) begin
            irq_next = 1'b1;
        end
        if (tx_end && i_enable && i_rst_n) begin
            irq_next = 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            tx_reg <= 1'b0;
            rx_reg <= 1'b0;
            no_rx_crc_reg <= 1'b0;
            mask_reg <= `RFIS_MASK_RESET;
            noresp_time_reg <= {NORESP_W{1'b0}};
            noresp_cnt_reg <= {NORESP_W{1'b0}};
            noresp_run_reg <= 1'b0;
            o_rdata <= 8'h00;
            o_rx_decoder_en <= 1'b0;
            o_tx_active <= 1'b0;
            o_rx_active <= 1'b0;
        end else begin
            o_irq <= irq_next;
            if (!i_enable) begin
                tx_reg <= 1'b0;
                rx_reg <= 1'b0;
                o_tx_active <= 1'b0;
                o_rx_active <= 1'b0;
                mask_reg <= `RFIS_MASK_RESET;
                noresp_run_reg <= 1'b0;
            end else begin
                // R7: transmit phase
                if (i_tx_start) begin
                    tx_reg <= 1'b1;
                    o_tx_active <= 1'b1;
                end else if (i_tx_done) begin
                    tx_reg <= 1'b0;
                    o_tx_active <= 1'b0;
                end
                // R8: receive phase
                if (i_rx_sof && !tx_reg) begin
                    rx_reg <= 1'b1;
                    o_rx_active <= 1'b1;
                end else if (i_rx_done) begin
                    rx_reg <= 1'b0;
                    o_rx_active <= 1'b0;
                end
                // R13: wait timer from end of transmit
                if (tx_end) begin
                    noresp_run_reg <= 1'b1;
                    noresp_cnt_reg <= {NORESP_W{1'b0}};
                end else if (i_rx_sof || noresp_hit || i_tx_start) begin
                    noresp_run_reg <= 1'b0;
                end else if (noresp_run_reg && i_noresp_tick) begin
                    noresp_cnt_reg <= noresp_cnt_reg + 1'b1;
                end
                if (i_wr) begin
                    if (i_addr == `RFIS_ADDR_PROTO_CTRL) begin
                        no_rx_crc_reg <= i_wdata[`RFIS_PROTO_NO_RX_CRC];
                    end else if (i_addr == `RFIS_ADDR_NORESP_TIME) begin
                        noresp_time_reg <= i_wdata[NORESP_W-1:0];
                    end else if (i_addr == `RFIS_ADDR_MASK) begin
                        mask_reg <= i_wdata[5:0];
                    end
                end
            end
            // R4: decoder off while transmitting
            o_rx_decoder_en <= i_enable && !(tx_reg || i_tx_start);
            if (i_rd) begin
                if (rd_status) begin
                    o_rdata <= flags;
                end else if (i_addr == `RFIS_ADDR_MASK) begin
                    o_rdata <= {2'b00, mask_reg};
                end else if (i_addr == `RFIS_ADDR_NORESP_TIME) begin
                    o_rdata <= noresp_time_ext[7:0];
                end else if (i_addr == `RFIS_ADDR_PROTO_CTRL) begin
                    o_rdata <= {no_rx_crc_reg, 7'h00};
                end else begin
                    o_rdata <= 8'h00;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== include/rfis_consts.vh ====
// Constants of the interrupt status and request logic.
`ifndef RFIS_CONSTS_VH
`define RFIS_CONSTS_VH
`define RFIS_ADDR_W 5
`define RFIS_ADDR_PROTO_CTRL 5'h01
`define RFIS_ADDR_NORESP_TIME 5'h07
`define RFIS_ADDR_STATUS 5'h0C
`define RFIS_ADDR_MASK 5'h0D
`define RFIS_STATUS_RESET 8'h00
`define RFIS_MASK_RESET 6'h3E
`define RFIS_BIT_TX 7
`define RFIS_BIT_RX 6
`define RFIS_BIT_FIFO 5
`define RFIS_BIT_CRC 4
`define RFIS_BIT_PARITY 3
`define RFIS_BIT_FRAMING 2
`define RFIS_BIT_COLL 1
`define RFIS_BIT_NORESP 0
`define RFIS_PROTO_NO_RX_CRC 7
`define RFIS_FIFO_HIGH 8
`define RFIS_FIFO_LOW 4
`endif

// ==== hdl/rfis_flag_bit.v ====
// One sticky status flag with set-wins-over-clear behaviour.
`timescale 1ns/1ps
`default_nettype none
module rfis_flag_bit (
    input wire i_clk,
    input wire i_clr,
    input wire i_set,
    output reg o_flag
);
    always @(posedge i_clk) begin
        if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rfis_irq_chk.sv ====
// Assertion checker of the interrupt status logic.
`timescale 1ns/1ps
`default_nettype none
`include "rfis_consts.vh"
module rfis_irq_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic [`RFIS_ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd_end,
    input wire logic i_tx_start,
    input wire logic i_tx_done,
    input wire logic i_rx_done,
    input wire logic i_noresp_tick,
    input wire logic o_irq,
    input wire logic o_rx_decoder_en,
    input wire logic o_tx_active,
    input wire logic o_rx_active
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_ack;
        i_rd_end && i_addr == `RFIS_ADDR_STATUS && !i_tx_done && !i_rx_done && !i_noresp_tick;
    endsequence
    a_irq_at_end: assert property (i_enable && !i_wr && (i_tx_done && o_tx_active ||
        i_rx_done && o_rx_active) |=> o_irq) else $error("irq late");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(i_tx_done) ||
        $past(i_rx_done) || $past(i_noresp_tick) || $past(i_noresp_tick, 2))
        else $error("irq cause");
    a_ack_clear: assert property (s_ack |=> !o_irq) else $error("irq kept");
    a_irq_hold: assert property (o_irq && i_enable && !i_rd_end && !i_wr |=> o_irq)
        else $error("irq dropped");
    a_enable_off: assert property (!i_enable |=> !o_irq && !o_tx_active && !o_rx_active)
        else $error("enable clear");
    a_tx_no_decode: assert property (o_tx_active |-> !o_rx_decoder_en)
        else $error("decoder on");
    a_tx_flag_set: assert property (i_tx_start && i_enable && !i_tx_done && !o_rx_active
        |=> o_tx_active) else $error("tx flag");
    a_tx_irq_wait: assert property (o_tx_active && !o_irq && !i_tx_done |=> !o_irq)
        else $error("early irq");
endmodule
bind rfis_irq_status rfis_irq_chk u_chk (.i_clk, .i_rst_n, .i_enable, .i_addr, .i_wr,
    .i_rd_end, .i_tx_start, .i_tx_done, .i_rx_done, .i_noresp_tick, .o_irq,
    .o_rx_decoder_en, .o_tx_active, .o_rx_active);
`default_nettype wire

// ==== tb/rfis_host_model.sv ====
// Host model that reaches the registers through the access strobes.
`timescale 1ns/1ps
`default_nettype none
module rfis_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [4:0] o_addr = 5'h00,
    output logic [7:0] o_wdata = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic o_rd_end = 1'b0
);
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_rd_end <= 1'b1;
        @(posedge i_clk);
        o_rd_end <= 1'b0;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ==== tb/rfis_irq_status_tb_top.sv ====
// Self-checking testbench of the interrupt status logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module rfis_irq_status_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [8:0] ev = 9'h000;
    logic [6:0] fifo = 7'h06;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, sts;
    logic wr, rd, rd_end, irq, dec, txa, rxa;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #10 clk = ~clk;
    rfis_irq_status u_rfis_irq_status (.i_clk(clk), .i_rst_n(rst_n), .i_enable(en),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_rd_end(rd_end),
        .i_tx_start(ev[8]), .i_tx_done(ev[7]), .i_rx_sof(ev[6]), .i_rx_done(ev[5]),
        .i_fifo_bits(fifo), .i_crc_err(ev[4]), .i_parity_err(ev[3]), .i_framing_err(ev[2]),
        .i_collision(ev[1]), .i_noresp_tick(ev[0]), .o_rdata(rdata), .o_irq(irq),
        .o_rx_decoder_en(dec), .o_tx_active(txa), .o_rx_active(rxa));
    rfis_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .o_rd_end(rd_end));
    task automatic ev_p(input logic [8:0] e, input logic [6:0] f);
        @(posedge clk);
        ev <= e;
        fifo <= f;
        @(posedge clk);
        ev <= 9'h000;
        #1;
    endtask
    task automatic exp_rd(input logic [4:0] a, input logic [7:0] e);
        host.rd(a, sts);
        #1;
        `CHK(sts, e)
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        exp_rd(5'h0C, 8'h00);
        exp_rd(5'h0D, 8'h3E);
        host.wr(5'h07, 8'h03);
        ev_p(9'h100, 7'h06);
        `CHK({irq, txa, dec}, 3'b010)
        ev_p(9'h008, 7'h02);
        ev_p(9'h080, 7'h06);
        `CHK(irq, 1'b1)
        exp_rd(5'h0C, 8'hA0);
        `CHK(irq, 1'b0)
        exp_rd(5'h0C, 8'h00);
        ev_p(9'h040, 7'h06);
        `CHK({irq, rxa}, 2'b01)
        ev_p(9'h010, 7'h09);
        ev_p(9'h020, 7'h06);
        `CHK({irq, rxa}, 2'b10)
        ev_p(9'h01E, 7'h06);
        exp_rd(5'h0C, 8'h5E);
        host.wr(5'h01, 8'h80);
        ev_p(9'h010, 7'h06);
        exp_rd(5'h0C, 8'h00);
        ev_p(9'h008, 7'h06);
        host.wr(5'h01, 8'h00);
        exp_rd(5'h0C, 8'h00);
        host.wr(5'h07, 8'h03);
        for (int i = 0; i < 2; i++) begin
            host.wr(5'h0D, 8'h3E | 8'(i));
            ev_p(9'h100, 7'h06);
            ev_p(9'h080, 7'h06);
            host.rd(5'h0C, sts);
            repeat (5) ev_p(9'h001, 7'h06);
            `CHK(irq, i[0])
        end
        exp_rd(5'h0C, 8'h01);
        ev_p(9'h002, 7'h06);
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        exp_rd(5'h0C, 8'h00);
        results();
    end
endmodule
`default_nettype wire
